// file: logic/pwm_pkg.sv
// pwm_pkg: register map, field positions, reset values and widths of one pwm channel
// assumes a 32-bit apb slave and a shared 8-bit period timer living outside the channel
package pwm_pkg;

    // register byte offsets
    localparam logic [11:0] CTRL_OFFSET      = 12'h000;
    localparam logic [11:0] DUTY_HIGH_OFFSET = 12'h004;
    localparam logic [11:0] DUTY_LOW_OFFSET  = 12'h008;

    // channel_control field positions
    localparam int unsigned MODULE_ENABLE_POS = 7;
    localparam int unsigned PIN_DRIVE_POS     = 6;
    localparam int unsigned OUTPUT_VALUE_POS  = 5;
    localparam int unsigned POLARITY_POS      = 4;

    // duty_low_bits field position (two bits at 7..6)
    localparam int unsigned DUTY_LOW_POS = 6;

    // widths
    localparam int unsigned DUTY_W  = 10;
    localparam int unsigned TIMER_W = 8;

    // values after reset
    localparam logic        CTRL_BIT_RESET = 1'b0;
    localparam logic [9:0]  DUTY_RESET     = 10'h000;
    localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;

endpackage

// file: logic/pwm_duty_compare.sv
// pwm_duty_compare: double-buffered duty compare and raw (active-high) waveform of one channel
// assumes timeBase, periodValue and periodMatch come from the shared timer on the same clock
module pwm_duty_compare
    import pwm_pkg::*;
#(
    parameter int unsigned DW = DUTY_W,
    parameter int unsigned TW = TIMER_W
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          cke,
    // control
    input  wire logic          enable,
    input  wire logic [DW-1:0] dutyNew,
    // shared time base
    input  wire logic [DW-1:0] timeBase,
    input  wire logic [TW-1:0] periodValue,
    input  wire logic          periodMatch,
    // waveform
    output logic               waveActive
);

    logic [DW-1:0] dutyBuf_ff;
    logic          wave_ff;
    logic [DW:0]   periodSpan;
    logic          fullDuty;
    logic          dutyHit;

    // one period spans 4*(period+1) time-base steps
    assign periodSpan = {({1'b0, periodValue} + (TW+1)'(1)), 2'b00};
    assign fullDuty   = {1'b0, dutyBuf_ff} >= periodSpan;
    assign dutyHit    = (timeBase == dutyBuf_ff) && !fullDuty;
    assign waveActive = wave_ff;

    // buffers copy only at the period match so a half-written pair reaches the compare only when a match falls between its two writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dutyBuf_ff <= DUTY_RESET;
        end else if (cke && periodMatch) begin
            dutyBuf_ff <= dutyNew;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_ff <= 1'b0;
        end else if (cke) begin
            if (!enable) begin
                wave_ff <= 1'b0;
            end else if (periodMatch) begin
                wave_ff <= (dutyNew != DUTY_RESET);
            end else if (dutyHit) begin
                wave_ff <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !cke);

    property p_period_start;
        enable && periodMatch && (dutyNew != DUTY_RESET) |=> waveActive;
    endproperty
    a_period_start: assert property (p_period_start) else $error("wave not set at period start");

    property p_zero_duty;
        enable && periodMatch && (dutyNew == DUTY_RESET) |=> !waveActive;
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("zero duty raised the wave");

    property p_duty_clear;
        enable && !periodMatch && (timeBase == dutyBuf_ff) && !fullDuty |=> !waveActive;
    endproperty
    a_duty_clear: assert property (p_duty_clear) else $error("wave not cleared at duty match");

    property p_full_duty;
        enable && waveActive && fullDuty && !periodMatch |=> waveActive;
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("full duty wave dropped");

    property p_buffer_hold;
        !periodMatch |=> $stable(dutyBuf_ff);
    endproperty
    a_buffer_hold: assert property (p_buffer_hold) else $error("duty buffer moved off the match");

    property p_disabled;
        !enable |=> !waveActive;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled channel shows wave");

    c_full_period: cover property (enable && waveActive && fullDuty ##1 periodMatch);

endmodule // pwm_duty_compare

// file: logic/pwm_control_and_duty_regs.sv
// pwm_control_and_duty_regs: apb register set and pin output of one pwm channel
// assumes an apb master on clk and a shared period timer (time base, period, match) on clk
module pwm_control_and_duty_regs
    import pwm_pkg::*;
#(
    parameter int unsigned AW = 12
) (
    // clock, reset, clock enable
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           cke,
    input  wire logic           softReset,
    // apb slave
    input  wire logic [AW-1:0]  paddr,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [31:0]    pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    // shared period timer
    input  wire logic [DUTY_W-1:0]  timeBase,
    input  wire logic [TIMER_W-1:0] periodValue,
    input  wire logic               periodMatch,
    // pin
    output logic                pinOut,
    output logic                pinOutEnable
);

    logic              moduleEnable_ff;
    logic              pinDrive_ff;
    logic              polarity_ff;
    logic [7:0]        dutyHigh_ff;
    logic [1:0]        dutyLow_ff;
    logic              outValue_ff;
    logic              pinOe_ff;
    logic [31:0]       prdata_ff;
    logic              pready_ff;
    logic              pslverr_ff;
    logic [31:0]       nxt_prdata;
    logic              nxt_pslverr;
    logic              setupPhase;
    logic              writeDone;
    logic              hitCtrl;
    logic              hitHigh;
    logic              hitLow;
    logic              waveActive;
    logic [DUTY_W-1:0] dutyValue;

    assign setupPhase = psel && !penable;
    assign writeDone  = psel && penable && pready_ff && pwrite && !pslverr_ff;
    assign hitCtrl    = (paddr == AW'(CTRL_OFFSET));
    assign hitHigh    = (paddr == AW'(DUTY_HIGH_OFFSET));
    assign hitLow     = (paddr == AW'(DUTY_LOW_OFFSET));
    assign dutyValue  = {dutyHigh_ff, dutyLow_ff};

    assign prdata       = prdata_ff;
    assign pready       = pready_ff;
    assign pslverr      = pslverr_ff;
    assign pinOut       = outValue_ff;
    assign pinOutEnable = pinOe_ff;

    // control bits: both resets clear them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            moduleEnable_ff <= CTRL_BIT_RESET;
            pinDrive_ff     <= CTRL_BIT_RESET;
            polarity_ff     <= CTRL_BIT_RESET;
        end else if (cke) begin
            if (softReset) begin
                moduleEnable_ff <= CTRL_BIT_RESET;
                pinDrive_ff     <= CTRL_BIT_RESET;
                polarity_ff     <= CTRL_BIT_RESET;
            end else if (writeDone && hitCtrl) begin
                moduleEnable_ff <= pwdata[MODULE_ENABLE_POS];
                pinDrive_ff     <= pwdata[PIN_DRIVE_POS];
                polarity_ff     <= pwdata[POLARITY_POS];
            end
        end
    end

    // duty pair: only power-on reset touches it; the soft reset leaves it alone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dutyHigh_ff <= DUTY_RESET[DUTY_W-1:2];
            dutyLow_ff  <= DUTY_RESET[1:0];
        end else if (cke && !softReset) begin
            if (writeDone && hitHigh) begin
                dutyHigh_ff <= pwdata[7:0];
            end
            if (writeDone && hitLow) begin
                dutyLow_ff <= pwdata[DUTY_LOW_POS +: 2];
            end
        end
    end

    pwm_duty_compare #(
        .DW (DUTY_W),
        .TW (TIMER_W)
    ) u_compare (
        .clk         (clk),
        .rst_n       (rst_n),
        .cke         (cke),
        .enable      (moduleEnable_ff),
        .dutyNew     (dutyValue),
        .timeBase    (timeBase),
        .periodValue (periodValue),
        .periodMatch (periodMatch),
        .waveActive  (waveActive)
    );

    // pin output registered so the pin and the read-back bit never disagree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outValue_ff <= CTRL_BIT_RESET;
            pinOe_ff    <= CTRL_BIT_RESET;
        end else if (cke) begin
            outValue_ff <= waveActive ^ polarity_ff;
            pinOe_ff    <= pinDrive_ff && !softReset;
        end
    end

    // read data prepared in the setup cycle; reserved bits read zero
    always_comb begin
        nxt_prdata  = RDATA_RESET;
        nxt_pslverr = 1'b0;
        if (hitCtrl) begin
            nxt_prdata[MODULE_ENABLE_POS] = moduleEnable_ff;
            nxt_prdata[PIN_DRIVE_POS]     = pinDrive_ff;
            nxt_prdata[OUTPUT_VALUE_POS]  = outValue_ff;
            nxt_prdata[POLARITY_POS]      = polarity_ff;
        end else if (hitHigh) begin
            nxt_prdata[7:0] = dutyHigh_ff;
        end else if (hitLow) begin
            nxt_prdata[DUTY_LOW_POS +: 2] = dutyLow_ff;
        end else begin
            nxt_pslverr = 1'b1;
        end
    end

    // one wait-free access: pready rises with the first access cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_ff  <= RDATA_RESET;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else if (cke) begin
            pready_ff  <= setupPhase;
            pslverr_ff <= setupPhase && nxt_pslverr;
            if (setupPhase && !pwrite) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !cke);

    property p_enable_write;
        writeDone && hitCtrl && !softReset |=> moduleEnable_ff == $past(pwdata[MODULE_ENABLE_POS]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable bit not written");

    property p_pin_enable;
        !softReset && pinDrive_ff |=> pinOutEnable;
    endproperty
    a_pin_enable: assert property (p_pin_enable) else $error("pin not driven while enabled");

    property p_pin_release;
        !pinDrive_ff |=> !pinOutEnable;
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("pin driven while released");

    property p_readback;
        setupPhase && !pwrite && hitCtrl |=> prdata[OUTPUT_VALUE_POS] == $past(outValue_ff) && prdata[3:0] == 4'h0;
    endproperty
    a_readback: assert property (p_readback) else $error("output value read-back wrong");

    property p_polarity;
        !moduleEnable_ff ##1 !moduleEnable_ff |=> pinOut == $past(polarity_ff);
    endproperty
    a_polarity: assert property (p_polarity) else $error("idle level ignores polarity");

    property p_high_write;
        writeDone && hitHigh && !softReset |=> dutyHigh_ff == $past(pwdata[7:0]);
    endproperty
    a_high_write: assert property (p_high_write) else $error("duty high not written");

    property p_low_read;
        setupPhase && !pwrite && hitLow |=> prdata[5:0] == 6'h00 && prdata[7:6] == $past(dutyLow_ff);
    endproperty
    a_low_read: assert property (p_low_read) else $error("duty low read wrong");

    property p_soft_reset;
        softReset |=> !moduleEnable_ff && !pinDrive_ff && !polarity_ff && $stable(dutyValue);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset handling wrong");

    property p_setup_answer;
        setupPhase |=> pready && (pslverr == $past(nxt_pslverr));
    endproperty
    a_setup_answer: assert property (p_setup_answer) else $error("apb answer late or wrong");

    c_write_ctrl: cover property (writeDone && hitCtrl && pwdata[MODULE_ENABLE_POS]);
    c_read_ctrl: cover property (setupPhase && !pwrite && hitCtrl ##1 prdata[OUTPUT_VALUE_POS]);
    c_unmapped: cover property (setupPhase && nxt_pslverr);
    c_inverted_run: cover property (moduleEnable_ff && polarity_ff && pinOutEnable);

endmodule // pwm_control_and_duty_regs

// file: verif/pwm_control_and_duty_regs_tb.sv
// pwm_control_and_duty_regs_tb: apb master, bench period timer and cycle model of one pwm channel
// drives cke low for a few cycles in each waveform run and takes offsets and widths from pwm_pkg; field positions are written out as literals
module pwm_control_and_duty_regs_tb
    import pwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                clk, rst_n, cke, softReset, psel, penable, pwrite, pready, pslverr;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic                err, pinOut, pinOutEnable, periodMatch;
    logic [DUTY_W-1:0]   timeBase;
    logic [TIMER_W-1:0]  periodValue;
    logic                mEn, mOe, mPol, wave_ff, pinExp_ff, oeExp_ff;
    int                  seed, nErrors, numChecks, periodLen, mDuty, bufDuty_ff;

    pwm_control_and_duty_regs dut (.clk(clk), .rst_n(rst_n), .cke(cke), .softReset(softReset),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timeBase(timeBase),
        .periodValue(periodValue), .periodMatch(periodMatch), .pinOut(pinOut),
        .pinOutEnable(pinOutEnable));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // shared timer stand-in: match pulse coincides with the time base at zero
    // it holds while cke is low, like the rest of the clock domain
    always @(posedge clk) begin
        if (cke) begin
            timeBase    <= (timeBase == DUTY_W'(periodLen - 1)) ? '0 : timeBase + 1'b1;
            periodMatch <= (timeBase == DUTY_W'(periodLen - 1));
        end
    end

    // channel model: wave register, then pin one cycle later through polarity
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {mEn, mOe, mPol, wave_ff, pinExp_ff, oeExp_ff} <= '0;
            mDuty      <= 0;
            bufDuty_ff <= 0;
        end else if (cke) begin
            pinExp_ff <= wave_ff ^ mPol;
            // pin enable is registered one cycle behind the control bit
            oeExp_ff  <= mOe && !softReset;
            if (!mEn) wave_ff <= 1'b0;
            else if (periodMatch) wave_ff <= (mDuty != 0);
            else if (timeBase == bufDuty_ff && bufDuty_ff < periodLen) wave_ff <= 1'b0;
            if (periodMatch) bufDuty_ff <= mDuty;
            if (softReset) {mEn, mOe, mPol} <= '0;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(negedge clk) begin
        if (rst_n === 1'b1) begin
            chk({31'h0, pinOut}, {31'h0, pinExp_ff});
            chk({31'h0, pinOutEnable}, {31'h0, oeExp_ff});
        end
    end

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        // idle edge first, so a release and the next request never share a time step
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
        if (a == CTRL_OFFSET) {mEn, mOe, mPol} <= {d[7], d[6], d[4]};
        if (a == DUTY_HIGH_OFFSET) mDuty <= (int'(d[7:0]) << 2) | (mDuty & 3);
        if (a == DUTY_LOW_OFFSET) mDuty <= (mDuty & 'h3fc) | int'(d[7:6]);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] mask);
        logic [31:0] exp;
        apb(a, 1'b0, 32'h0);
        exp = (a == CTRL_OFFSET) ? {24'h0, mEn, mOe, 1'b0, mPol, 4'h0} :
              (a == DUTY_HIGH_OFFSET) ? 32'(mDuty >> 2) :
              (a == DUTY_LOW_OFFSET) ? 32'((mDuty & 3) << 6) : 32'h0;
        chk(rd & mask, exp & mask);
        chk({31'h0, err}, {31'h0, a > DUTY_LOW_OFFSET});
    endtask

    task complete_run;
        $display("checks=%0d errors=%0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // bound of 30000 cycles lies over ten times above the longest run, waveform phase and register traffic included
    initial begin
        #(30000 * 50);
        nErrors++;
        $display("timeout at t=%0t", $time);
        complete_run;
    end

    initial begin
        int duties[7];
        seed = 37428;
        {rst_n, softReset, psel, penable, pwrite, periodMatch} = '0;
        cke = 1'b1;
        paddr = '0;
        pwdata = '0;
        timeBase = '0;
        periodValue = TIMER_W'(2 + ($unsigned($random(seed)) % 8));
        periodLen = 4 * (int'(periodValue) + 1);
        duties = '{0, 1, periodLen / 2, periodLen - 1, periodLen, 1023, $unsigned($random(seed)) % 1024};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 16; a += 4) rdchk(12'(a), 32'hffffffff);
        $display("reset values done");
        for (int i = 0; i < 6; i++) begin
            wr(DUTY_HIGH_OFFSET, $random(seed));
            wr(DUTY_LOW_OFFSET, $random(seed));
            wr(CTRL_OFFSET, $random(seed));
            wr(12'h00c, $random(seed));
            for (int a = 0; a < 16; a += 4) rdchk(12'(a), 32'hffffffdf);
        end
        $display("register access done");
        wr(CTRL_OFFSET, 32'h20);
        repeat (3) @(posedge clk);
        rdchk(CTRL_OFFSET, 32'hffffffff);
        wr(CTRL_OFFSET, 32'h50);
        repeat (periodLen) @(posedge clk);
        apb(CTRL_OFFSET, 1'b0, 32'h0);
        chk(rd, 32'h70);
        $display("output value bit done");
        foreach (duties[k]) begin
            for (int p = 0; p < 2; p++) begin
                wr(DUTY_HIGH_OFFSET, 32'(duties[k] >> 2));
                wr(DUTY_LOW_OFFSET, 32'((duties[k] & 3) << 6));
                wr(CTRL_OFFSET, 32'hc0 | 32'(p << 4));
                // clock enable low: design, timer and model all hold their state
                cke <= 1'b0;
                repeat (p + 2) @(posedge clk);
                cke <= 1'b1;
                repeat (3 * periodLen) @(posedge clk);
            end
        end
        $display("waveform done");
        softReset <= 1'b1;
        @(posedge clk);
        softReset <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 12; a += 4) rdchk(12'(a), 32'hffffffff);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 12; a += 4) rdchk(12'(a), 32'hffffffff);
        $display("resets done");
        complete_run;
    end
endmodule // pwm_control_and_duty_regs_tb
